// ---- core/smp_pwm_out.sv ----
// output-waveform stage of the switch-mode pwm: pulse-skip, full bridge,
// variable frequency, with dead band and avalon-mm register access
// assumes period/rise/fall events are one-cycle pulses on clk; qualifiers are async pins
`default_nettype none

module smp_pwm_out #(
  parameter int N_SRC = 4                            // async rising qualifier count
) (
  input  wire logic                       clk,          // 50 MHz module clock
  input  wire logic                       rstn,         // async reset, active low
  input  wire logic                       period_evt,   // period event pulse
  input  wire logic                       rise_evt,     // synchronous rising event pulse
  input  wire logic                       fall_evt,     // falling event pulse
  input  wire logic [N_SRC-1:0]           rise_src_async, // async rising sources
  input  wire logic [smp_pkg::ADDR_W-1:0] avs_address,  // byte address
  input  wire logic                       avs_read,     // read strobe
  input  wire logic                       avs_write,    // write strobe
  input  wire logic [31:0]                avs_writedata, // write data
  output logic      [31:0]                avs_readdata, // read data
  output logic                            avs_waitrequest, // stall
  output var smp_pkg::smp_pins_s          out_pins      // pins a..d
);

  // ****************************************
  // parameter check
  // ****************************************
  if (N_SRC < 1 || N_SRC > 16) begin : g_bad_nsrc
    $error("N_SRC must be 1..16");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [N_SRC-1:0]   sync1;
    logic [N_SRC-1:0]   sync2;
    logic [N_SRC-1:0]   rise_mask;
    logic [2:0]         mode;
    logic [2:0]         mode_prev;
    logic               dbr_en;
    logic               dbf_en;
    logic [7:0]         dbr_val;
    logic [7:0]         dbf_val;
    logic [7:0]         r_cnt;
    logic [7:0]         f_cnt;
    logic               r_busy;
    logic               f_busy;
    logic [3:0]         frac_adj;
    logic [3:0]         acc;
    logic               stretch;
    logic               dly;
    logic               armed;
    logic               pwm;
    smp_pkg::smp_fb_e   fb;
    logic               fb_tgt_rev;
    smp_pkg::smp_pins_s pins;
    logic               ack;
    logic [31:0]        rdata;
  } smp_state_s;

  smp_state_s s_q;
  smp_state_s s_d;

  // ****************************************
  // qualifier match per source
  // ****************************************
  logic [N_SRC-1:0] hit_v;
  logic             hit;

  for (genvar i = 0; i < N_SRC; i++) begin : g_hit
    assign hit_v[i] = s_q.sync2[i] & s_q.rise_mask[i];
  end
  // a qualifier tied to the phase timebase is always equal at period time,
  // so it fires every period or never; route a real feedback source here
  assign hit = |hit_v;

  // ****************************************
  // bus read mux
  // ****************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      smp_pkg::OFS_CTRL: begin
        rd_mux[smp_pkg::CTRL_MODE_LSB +: 3] = s_q.mode;
        rd_mux[smp_pkg::CTRL_DBRE_BIT]      = s_q.dbr_en;
        rd_mux[smp_pkg::CTRL_DBFE_BIT]      = s_q.dbf_en;
      end
      smp_pkg::OFS_RMASK: rd_mux[N_SRC-1:0] = s_q.rise_mask;
      smp_pkg::OFS_DBR:   rd_mux[7:0]       = s_q.dbr_val;
      smp_pkg::OFS_DBF:   rd_mux[7:0]       = s_q.dbf_val;
      smp_pkg::OFS_FRAC_ADJ: rd_mux[3:0]    = s_q.frac_adj;
      smp_pkg::OFS_STAT: begin
        rd_mux[smp_pkg::STAT_PINS_LSB +: 4] = s_q.pins;
        rd_mux[smp_pkg::STAT_ACC_LSB +: 4]  = s_q.acc;
        rd_mux[smp_pkg::STAT_ARM_BIT]       = s_q.armed;
        rd_mux[smp_pkg::STAT_RBSY_BIT]      = s_q.r_busy;
        rd_mux[smp_pkg::STAT_FBSY_BIT]      = s_q.f_busy;
        rd_mux[smp_pkg::STAT_SWCH_BIT]      = (s_q.fb == smp_pkg::SMP_FB_SW);
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  logic       is_psk;
  logic       is_vf;
  logic       is_fb;
  logic       is_comp;
  logic       go_on;
  logic       go_off;
  logic       vf_fire;
  logic [4:0] acc_sum;
  logic       mode_chg;

  assign is_psk  = (s_q.mode == smp_pkg::MODE_PSK) || (s_q.mode == smp_pkg::MODE_PSK_C);
  assign is_vf   = (s_q.mode == smp_pkg::MODE_VF) || (s_q.mode == smp_pkg::MODE_VF_C);
  assign is_fb   = (s_q.mode == smp_pkg::MODE_FB_FWD) || (s_q.mode == smp_pkg::MODE_FB_REV);
  assign is_comp = (s_q.mode == smp_pkg::MODE_PSK_C) || (s_q.mode == smp_pkg::MODE_VF_C);
  assign mode_chg = (s_q.mode != s_q.mode_prev);
  // a pending stretched period fires one clock late
  assign vf_fire = is_vf && ((period_evt && !s_q.stretch) || s_q.dly);
  assign acc_sum = {1'b0, s_q.acc} + {1'b0, s_q.frac_adj};

  always_comb begin
    s_d           = s_q;
    s_d.sync1     = rise_src_async;
    s_d.sync2     = s_q.sync1;
    s_d.mode_prev = s_q.mode;
    s_d.dly       = 1'b0;
    go_on         = 1'b0;
    go_off        = 1'b0;

    // dead-band counters, one per edge, stepping every clock
    if (s_q.r_busy) begin
      if ((s_q.r_cnt + 8'h01) >= s_q.dbr_val) begin
        s_d.r_busy = 1'b0;
        if (is_comp) begin
          s_d.pins.a = 1'b1;
        end
      end else begin
        s_d.r_cnt = s_q.r_cnt + 8'h01;
      end
    end
    if (s_q.f_busy) begin
      if ((s_q.f_cnt + 8'h01) >= s_q.dbf_val) begin
        s_d.f_busy = 1'b0;
        if (is_comp) begin
          s_d.pins.b = 1'b1;
        end
      end else begin
        s_d.f_cnt = s_q.f_cnt + 8'h01;
      end
    end

    // edge requests per mode
    if (is_psk) begin
      if (period_evt && hit) begin
        s_d.armed = 1'b1;
      end
      if (s_q.armed && rise_evt && !fall_evt) begin
        go_on     = 1'b1;
        s_d.armed = period_evt && hit;
      end
      go_off = fall_evt;
    end else if (is_fb) begin
      go_on  = rise_evt && !fall_evt;
      go_off = fall_evt;
    end else if (is_vf && vf_fire) begin
      // edge events are not looked at here
      go_on       = !s_q.pwm;
      go_off      = s_q.pwm;
      s_d.acc     = acc_sum[3:0];
      s_d.stretch = acc_sum[4];
    end
    if (is_vf && period_evt && s_q.stretch && !s_q.dly) begin
      s_d.dly     = 1'b1;
      s_d.stretch = 1'b0;
    end
    if (go_on) begin
      s_d.pwm = 1'b1;
    end
    if (go_off) begin
      s_d.pwm = 1'b0;
    end

    // pin drive
    if (is_comp) begin
      if (go_on) begin
        s_d.pins.b = 1'b0;
        s_d.f_busy = 1'b0;
        if (s_q.dbr_en && s_q.dbr_val != 8'h00) begin
          s_d.r_busy = 1'b1;
          s_d.r_cnt  = 8'h00;
        end else begin
          s_d.pins.a = 1'b1;
        end
      end
      if (go_off) begin
        s_d.pins.a = 1'b0;
        s_d.r_busy = 1'b0;
        if (s_q.dbf_en && s_q.dbf_val != 8'h00) begin
          s_d.f_busy = 1'b1;
          s_d.f_cnt  = 8'h00;
        end else begin
          s_d.pins.b = 1'b1;
        end
      end
      s_d.pins.c = 1'b0;
      s_d.pins.d = 1'b0;
    end else if (is_psk || is_vf) begin
      s_d.pins = '{d: 1'b0, c: 1'b0, b: 1'b0, a: s_d.pwm};
    end else if (is_fb) begin
      unique case (s_q.fb)
        smp_pkg::SMP_FB_FWD: s_d.pins = '{d: 1'b1, c: 1'b0, b: 1'b0, a: s_d.pwm};
        smp_pkg::SMP_FB_REV: s_d.pins = '{d: 1'b0, c: 1'b1, b: s_d.pwm, a: 1'b0};
        smp_pkg::SMP_FB_SW: begin
          s_d.pins = '{d: 1'b0, c: 1'b0, b: 1'b0, a: 1'b0};
          if (!s_q.r_busy && !s_q.f_busy) begin
            s_d.fb = s_q.fb_tgt_rev ? smp_pkg::SMP_FB_REV : smp_pkg::SMP_FB_FWD;
          end
        end
        default: s_d.fb = smp_pkg::SMP_FB_FWD;
      endcase
    end else begin
      s_d.pins = '{d: 1'b0, c: 1'b0, b: 1'b0, a: 1'b0};
    end

    // mode change: bridge reversal is timed, anything else restarts clean
    if (mode_chg) begin
      s_d.r_busy  = 1'b0;
      s_d.f_busy  = 1'b0;
      s_d.armed   = 1'b0;
      s_d.stretch = 1'b0;
      s_d.dly     = 1'b0;
      s_d.pwm     = 1'b0;
      s_d.pins    = '{d: 1'b0, c: 1'b0, b: 1'b0, a: 1'b0};
      s_d.fb_tgt_rev = (s_q.mode == smp_pkg::MODE_FB_REV);
      if (is_fb && (s_q.mode_prev == smp_pkg::MODE_FB_FWD ||
                    s_q.mode_prev == smp_pkg::MODE_FB_REV)) begin
        s_d.fb = smp_pkg::SMP_FB_SW;
        if (s_q.mode == smp_pkg::MODE_FB_REV) begin
          s_d.f_busy = s_q.dbf_en && s_q.dbf_val != 8'h00;
          s_d.f_cnt  = 8'h00;
        end else begin
          s_d.r_busy = s_q.dbr_en && s_q.dbr_val != 8'h00;
          s_d.r_cnt  = 8'h00;
        end
      end else begin
        s_d.fb = (s_q.mode == smp_pkg::MODE_FB_REV) ? smp_pkg::SMP_FB_REV
                                                    : smp_pkg::SMP_FB_FWD;
      end
    end

    // bus slave: one wait state, read data registered at the first edge, write at the second edge
    s_d.ack = (avs_read || avs_write) && !s_q.ack;
    if (avs_read && !s_q.ack) begin
      s_d.rdata = rd_mux;
    end
    if (avs_write && s_q.ack) begin
      unique case (avs_address)
        smp_pkg::OFS_CTRL: begin
          s_d.mode   = avs_writedata[smp_pkg::CTRL_MODE_LSB +: 3];
          s_d.dbr_en = avs_writedata[smp_pkg::CTRL_DBRE_BIT];
          s_d.dbf_en = avs_writedata[smp_pkg::CTRL_DBFE_BIT];
        end
        smp_pkg::OFS_RMASK: s_d.rise_mask = avs_writedata[N_SRC-1:0];
        smp_pkg::OFS_DBR:   s_d.dbr_val   = avs_writedata[7:0];
        smp_pkg::OFS_DBF:   s_d.dbf_val   = avs_writedata[7:0];
        smp_pkg::OFS_FRAC_ADJ: s_d.frac_adj = avs_writedata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q            <= '0;
      s_q.mode       <= smp_pkg::RST_MODE;
      s_q.mode_prev  <= smp_pkg::RST_MODE;
      s_q.dbr_val    <= smp_pkg::RST_DB;
      s_q.dbf_val    <= smp_pkg::RST_DB;
      s_q.frac_adj   <= smp_pkg::RST_FRAC_ADJ;
      s_q.fb         <= smp_pkg::SMP_FB_FWD;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign avs_readdata    = s_q.rdata;
  assign out_pins        = s_q.pins;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_PSK_FIRE: assert property (
    (s_q.mode == smp_pkg::MODE_PSK) && !mode_chg && s_q.armed && rise_evt && !fall_evt
      |=> out_pins.a)
    else $error("armed rising event did not raise A");

  AST_PSK_SKIP: assert property (
    (s_q.mode == smp_pkg::MODE_PSK) && !mode_chg && !s_q.armed && !out_pins.a
      && !(period_evt && hit) |=> !out_pins.a)
    else $error("pulse produced without qualified period");

  AST_PSK_FALL: assert property (
    is_psk && !mode_chg && fall_evt |=> !out_pins.a)
    else $error("falling event did not end pulse");

  AST_COMP_EXCL: assert property (
    is_comp |-> !(out_pins.a && out_pins.b))
    else $error("primary and complement both active");

  AST_DBR_HOLD: assert property (
    is_comp && !mode_chg && go_on && !go_off && s_q.dbr_en && s_q.dbr_val == 8'h02
      |=> !out_pins.a && !out_pins.b ##1 !out_pins.a ##1 out_pins.a)
    else $error("rising dead band length wrong");

  AST_FB_FWD: assert property (
    s_q.mode == smp_pkg::MODE_FB_FWD && s_q.fb == smp_pkg::SMP_FB_FWD && !mode_chg
      |=> out_pins.d && !out_pins.b && !out_pins.c && (out_pins.a == $past(s_d.pwm)))
    else $error("forward bridge pins wrong");

  AST_FB_REV: assert property (
    s_q.mode == smp_pkg::MODE_FB_REV && s_q.fb == smp_pkg::SMP_FB_REV && !mode_chg
      |=> out_pins.c && !out_pins.a && !out_pins.d)
    else $error("reverse bridge pins wrong");

  AST_FB_SWITCH: assert property (
    mode_chg && s_q.mode == smp_pkg::MODE_FB_REV && s_q.mode_prev == smp_pkg::MODE_FB_FWD
      && s_q.dbf_en && s_q.dbf_val == 8'h06
      |=> (out_pins == 4'h0)[*7] ##1 s_q.fb == smp_pkg::SMP_FB_REV)
    else $error("bridge reversal not timed by falling counter");

  AST_VF_TOGGLE: assert property (
    s_q.mode == smp_pkg::MODE_VF && !mode_chg && vf_fire |=> out_pins.a != $past(out_pins.a))
    else $error("A did not toggle on period event");

  AST_VF_ACC: assert property (
    is_vf && !mode_chg && vf_fire
      |=> s_q.acc == $past(acc_sum[3:0]) && s_q.stretch == $past(acc_sum[4]))
    else $error("accumulator not advanced by adjust");

  AST_VF_STRETCH: assert property (
    is_vf && !mode_chg && period_evt && s_q.stretch && !s_q.dly |=> vf_fire)
    else $error("stretched period not fired one clock late");

  AST_FB_REVERT: assert property (
    mode_chg && s_q.mode == smp_pkg::MODE_FB_FWD && s_q.mode_prev == smp_pkg::MODE_FB_REV
      && s_q.dbr_en && s_q.dbr_val == 8'h02
      |=> (out_pins == 4'h0)[*3] ##1 s_q.fb == smp_pkg::SMP_FB_FWD)
    else $error("bridge return not timed by rising counter");

  // arming must survive a consume in the same cycle
  AST_PSK_ARM: assert property (
    is_psk && !mode_chg && period_evt && hit |=> s_q.armed)
    else $error("qualified period event did not arm");

  AST_VF_HOLD: assert property (
    s_q.mode == smp_pkg::MODE_VF && !mode_chg && !vf_fire |=> out_pins.a == $past(out_pins.a))
    else $error("A changed without a period event");

endmodule : smp_pwm_out

`default_nettype wire

// ---- core/smp_pkg.sv ----
// constants, types and register map of the switch-mode pwm output stage
// assumes one 50 MHz clock; events arrive as one-cycle pulses from the timebase
//
// Operation
// - single pulse-skip: qualified period arms, next synchronous rising event raises A
// - pulse-skip: all qualifying sources low at period event means no pulse
// - pulse-skip: rising edge placed by the phase timebase event
// - pulse-skip: every falling event ends the pulse unconditionally
// - phase timebase as qualifier gives pulse every period or never
// - complementary pulse-skip: primary only on A, complement only on B
// - complementary rising: drop complement, rising dead band, raise primary
// - complementary pulse-skip falling: drop primary, falling dead band, raise complement
// - no steering: every output fixed to its own pin
// - full bridge uses single-pwm events and drives only A to D
// - full bridge direction chosen by the mode field
// - forward: D active, B and C inactive, A modulated
// - reverse: C active, A and D inactive, B modulated
// - forward to reverse change timed by falling dead-band counter
// - reverse to forward change timed by rising dead-band counter
// - variable frequency: A toggles each period event, edge events ignored
// - variable frequency: each period event adds 4-bit adjust to accumulator
// - single variable frequency drives A only
// - complementary variable frequency: A primary, B complement with dead band
// - rising A uses rising counter, falling A uses falling counter
// - A rising: drop B, update accumulator, rising dead band, raise A
// - A falling: drop A, update accumulator, falling dead band, raise B
// - separate 8-bit rising and falling dead-band counters
// - dead-band counters advance on every clock edge; here only rising clk edges step them
`default_nettype none

package smp_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_RMASK    = 8'h04;
  localparam logic [7:0]  OFS_DBR      = 8'h08;
  localparam logic [7:0]  OFS_DBF      = 8'h0c;
  localparam logic [7:0]  OFS_FRAC_ADJ = 8'h10;
  localparam logic [7:0]  OFS_STAT     = 8'h14;

  // ctrl fields
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_DBRE_BIT = 4;
  localparam int          CTRL_DBFE_BIT = 5;

  // status fields
  localparam int          STAT_PINS_LSB = 0;
  localparam int          STAT_ACC_LSB  = 4;
  localparam int          STAT_ARM_BIT  = 8;
  localparam int          STAT_RBSY_BIT = 9;
  localparam int          STAT_FBSY_BIT = 10;
  localparam int          STAT_SWCH_BIT = 11;

  // reset values
  localparam logic [2:0]  RST_MODE     = 3'h0;
  localparam logic [7:0]  RST_DB       = 8'h00;
  localparam logic [3:0]  RST_FRAC_ADJ = 4'h0;

  // ****************************************
  // mode codes of the ctrl mode field
  // ****************************************
  localparam logic [2:0]  MODE_OFF     = 3'h0;
  localparam logic [2:0]  MODE_PSK     = 3'h1;
  localparam logic [2:0]  MODE_PSK_C   = 3'h2;
  localparam logic [2:0]  MODE_FB_FWD  = 3'h3;
  localparam logic [2:0]  MODE_FB_REV  = 3'h4;
  localparam logic [2:0]  MODE_VF      = 3'h5;
  localparam logic [2:0]  MODE_VF_C    = 3'h6;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SMP_FB_FWD = 3'b001,
    SMP_FB_REV = 3'b010,
    SMP_FB_SW  = 3'b100
  } smp_fb_e;

  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } smp_pins_s;

endpackage : smp_pkg

`default_nettype wire

// ---- dv/smp_bridge_drv.sv ----
// gate-driver model of the bridge power switches fed by the pwm pins
// assumes pins a/b form one leg and c/d the other, sampled on clk
`default_nettype none

module smp_bridge_drv (
  input  wire logic               clk,       // module clock
  input  wire logic               rstn,      // async reset, active low
  input  wire smp_pkg::smp_pins_s pins,      // gate drives a..d
  output logic [15:0]             shoot_cnt  // cycles with both switches of a leg on
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // shoot-through watch
  // ****************************************
  // a real bridge would short the rail here, so every such cycle is counted
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shoot_cnt <= 16'h0;
    end else if ((pins.a & pins.b) | (pins.c & pins.d)) begin
      shoot_cnt <= shoot_cnt + 16'h1;
    end
  end
endmodule // smp_bridge_drv

`default_nettype wire

// ---- dv/smp_pwm_out_bench.sv ----
// self-checking bench of the switch-mode pwm output stage
// assumes the gate-driver model beside it and a 50 MHz clock
`default_nettype none

module smp_pwm_out_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic               clk;
  logic               rstn;
  logic               period_evt;
  logic               rise_evt;
  logic               fall_evt;
  logic [3:0]         rise_src_async;
  logic [7:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  smp_pkg::smp_pins_s out_pins;
  logic [15:0]        shoot_cnt;
  logic [31:0]        rd;
  int                 n_mismatch = 0;
  int                 cmp_count = 0;
  int                 cycles = 0;
  int                 cnt;

  smp_pwm_out #(.N_SRC(4)) smp_pwm_out_inst (
    .clk(clk), .rstn(rstn), .period_evt(period_evt), .rise_evt(rise_evt),
    .fall_evt(fall_evt), .rise_src_async(rise_src_async), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .out_pins(out_pins));

  smp_bridge_drv smp_bridge_drv_inst (
    .clk(clk), .rstn(rstn), .pins(out_pins), .shoot_cnt(shoot_cnt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one avalon access; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask

  // k: 0 period, 1 rising, 2 falling; one-cycle pulse
  task automatic evt(input int k);
    @(posedge clk);
    period_evt <= (k == 0);
    rise_evt <= (k == 1);
    fall_evt <= (k == 2);
    @(posedge clk);
    period_evt <= 1'b0;
    rise_evt <= 1'b0;
    fall_evt <= 1'b0;
  endtask

  task automatic cp(input string nm, input logic [3:0] e);
    @(negedge clk);
    check(nm, {28'h0, out_pins}, {28'h0, e});
  endtask

  // cycles from the end of a mode write until the pins show e
  task automatic wait_pins(input logic [3:0] e);
    cnt = 0;
    @(negedge clk);
    while (out_pins !== e && cnt < 40) begin
      cnt++;
      @(negedge clk);
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("[FAIL] run length expected below 20000 seen %0d", cycles);
      wrap_up();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    period_evt = 1'b0;
    rise_evt = 1'b0;
    fall_evt = 1'b0;
    rise_src_async = 4'h0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    cp("pins after reset", 4'h0);
    rdchk("ctrl", smp_pkg::OFS_CTRL, 32'h0);
    rdchk("frac adjust", smp_pkg::OFS_FRAC_ADJ, 32'h0);
    rdchk("stat", smp_pkg::OFS_STAT, 32'h0);
    wr(8'h18, 32'hffffffff);
    rdchk("unmapped", 8'h18, 32'h0);
    wr(smp_pkg::OFS_DBR, 32'h1ff);
    rdchk("dbr width", smp_pkg::OFS_DBR, 32'hff);
    // pulse skip: only qualifier 1 enabled
    wr(smp_pkg::OFS_RMASK, 32'h2);
    wr(smp_pkg::OFS_CTRL, {29'h0, smp_pkg::MODE_PSK});
    rise_src_async <= 4'h4;
    repeat (4) @(posedge clk);
    evt(0);
    evt(1);
    cp("masked source skips", 4'h0);
    @(posedge clk);
    rise_src_async <= 4'h2;
    evt(1);
    cp("rise unarmed", 4'h0);
    repeat (3) @(posedge clk);
    evt(0);
    cp("period alone", 4'h0);
    evt(1);
    cp("pulse on rise", 4'h1);
    evt(2);
    cp("fall ends pulse", 4'h0);
    evt(0);
    evt(1);
    cp("held source pulses again", 4'h1);
    evt(2);
    // complementary pulse skip, dead band 2 rising, 3 falling
    wr(smp_pkg::OFS_DBR, 32'h2);
    wr(smp_pkg::OFS_DBF, 32'h3);
    wr(smp_pkg::OFS_CTRL, {26'h0, 2'b11, 1'b0, smp_pkg::MODE_PSK_C});
    repeat (3) @(posedge clk);
    evt(0);
    evt(1);
    cp("comp rise +1", 4'h0);
    cp("comp rise +2", 4'h0);
    cp("comp rise +3", 4'h1);
    evt(2);
    repeat (3) cp("comp fall gap", 4'h0);
    cp("comp fall +4", 4'h2);
    // full bridge; unequal dead bands tell the counters apart
    wr(smp_pkg::OFS_DBF, 32'h6);
    wr(smp_pkg::OFS_CTRL, {26'h0, 2'b11, 1'b0, smp_pkg::MODE_FB_FWD});
    wait_pins(4'h8);
    cp("fwd static", 4'h8);
    evt(1);
    cp("fwd rise", 4'h9);
    evt(2);
    cp("fwd fall", 4'h8);
    wr(smp_pkg::OFS_CTRL, {26'h0, 2'b11, 1'b0, smp_pkg::MODE_FB_REV});
    wait_pins(4'h4);
    check("to reverse delay", {31'h0, cnt >= 6 && cnt <= 10}, 32'h1);
    evt(1);
    cp("rev rise", 4'h6);
    evt(2);
    cp("rev fall", 4'h4);
    wr(smp_pkg::OFS_CTRL, {26'h0, 2'b11, 1'b0, smp_pkg::MODE_FB_FWD});
    wait_pins(4'h8);
    check("to forward delay", {31'h0, cnt >= 2 && cnt <= 6}, 32'h1);
    // variable frequency, adjust 5
    wr(smp_pkg::OFS_FRAC_ADJ, 32'h5);
    wr(smp_pkg::OFS_CTRL, {29'h0, smp_pkg::MODE_VF});
    repeat (3) @(posedge clk);
    evt(0);
    cp("vf toggle up", 4'h1);
    evt(1);
    evt(2);
    cp("vf edges ignored", 4'h1);
    bus(1'b0, smp_pkg::OFS_STAT, 32'h0);
    check("acc one step", {28'h0, rd[7:4]}, 32'h5);
    evt(0);
    cp("vf toggle down", 4'h0);
    evt(0);
    evt(0);
    cp("vf fourth", 4'h0);
    bus(1'b0, smp_pkg::OFS_STAT, 32'h0);
    check("acc wrapped", {28'h0, rd[7:4]}, 32'h4);
    evt(0);
    cp("stretched +1", 4'h0);
    cp("stretched +2", 4'h1);
    // complementary variable frequency, dead band 2 rising, 6 falling
    wr(smp_pkg::OFS_CTRL, {26'h0, 2'b11, 1'b0, smp_pkg::MODE_VF_C});
    repeat (3) @(posedge clk);
    evt(0);
    repeat (2) cp("vfc rise gap", 4'h0);
    cp("vfc rise +3", 4'h1);
    evt(0);
    repeat (6) cp("vfc fall gap", 4'h0);
    cp("vfc fall +7", 4'h2);
    check("shoot through cycles", {16'h0, shoot_cnt}, 32'h0);
    wrap_up();
  end
endmodule // smp_pwm_out_bench

`default_nettype wire
